// ==== inc/timer0_pkg.sv ====
// Constants shared by the timer counter and its two compare channels.
// Assumes an 8-bit counter advanced by a one-cycle timer tick input.
`default_nettype none

package timer0_pkg;

    // ************************************************************
    // Counter geometry and reset values
    // ************************************************************
    localparam int         CNT_W       = 8;
    localparam logic       WAVE_RST    = 1'b0;
    localparam logic       FLAG_RST    = 1'b0;
    localparam logic       BLOCK_RST   = 1'b0;

    // ************************************************************
    // Waveform mode select codes
    // ************************************************************
    localparam logic [2:0] WGM_NORMAL    = 3'h0;
    localparam logic [2:0] WGM_CLR_MATCH = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX  = 3'h3;
    localparam logic [2:0] WGM_FAST_OCRA = 3'h7;
    localparam int         WGM_BIT2      = 2;

    // ************************************************************
    // Compare output mode codes and clock source
    // ************************************************************
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;
    localparam logic [2:0] CS_STOPPED = 3'h0;

endpackage

`default_nettype wire

// ==== verilog/compare_channel.sv ====
// One compare channel: compare register pair, match detect, wave register
// and the port pin override.
// Assumes the counter, blocking flag and timer tick come from the parent.
`default_nettype none
`timescale 1ns/10ps

module compare_channel #(
    parameter int CNT_W = timer0_pkg::CNT_W
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] count,
    input  wire logic             block,
    input  wire logic             wr,
    input  wire logic [CNT_W-1:0] wdata,
    input  wire logic             fast_pwm,
    input  wire logic             at_top,
    input  wire logic [1:0]       com,
    input  wire logic             toggle_ok,
    input  wire logic             force_strobe,
    input  wire logic             port_data,
    input  wire logic             port_dir,
    output logic [CNT_W-1:0]      compare_value,
    output logic [CNT_W-1:0]      active_value,
    output logic                  match,
    output logic                  wave_out,
    output logic                  pin_out,
    output logic                  pin_oe
);
    import timer0_pkg::*;

    logic [CNT_W-1:0] buffer_ff;
    logic [CNT_W-1:0] active_ff;
    logic             wave_ff;

    // ************************************************************
    // Compare registers
    // ************************************************************
    // Software always lands in the buffer; readback shows the buffer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            buffer_ff <= '0;
        end else if (wr) begin
            buffer_ff <= wdata;
        end
    end

    // Direct in non-PWM, reloaded only at TOP to BOTTOM in fast PWM
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            active_ff <= '0;
        end else if (!fast_pwm) begin
            if (wr) begin
                active_ff <= wdata;
            end
        end else if (run && at_top) begin
            active_ff <= buffer_ff;
        end
    end

    // Equality only counts on a timer tick not blocked by a count write
    assign match = run && !block && (count == active_ff);

    // ************************************************************
    // Wave register
    // ************************************************************
    // Mode changes never touch it, so the level survives a mode switch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wave_ff <= WAVE_RST;
        end else if (!fast_pwm) begin
            if (match || force_strobe) begin
                case (com)
                    COM_TOGGLE: wave_ff <= ~wave_ff;
                    COM_CLEAR:  wave_ff <= 1'b0;
                    COM_SET:    wave_ff <= 1'b1;
                    default:    wave_ff <= wave_ff;
                endcase
            end
        end else begin
            if (match) begin
                case (com)
                    COM_TOGGLE: wave_ff <= toggle_ok ? ~wave_ff : wave_ff;
                    COM_CLEAR:  wave_ff <= 1'b0;
                    COM_SET:    wave_ff <= 1'b1;
                    default:    wave_ff <= wave_ff;
                endcase
            end
            // BOTTOM wins over a match at TOP so MAX gives a flat level
            if (run && at_top) begin
                case (com)
                    COM_CLEAR: wave_ff <= 1'b1;
                    COM_SET:   wave_ff <= 1'b0;
                    default:   ; // Keeps a toggle at TOP alive
                endcase
            end
        end
    end

    // ************************************************************
    // Pin override
    // ************************************************************
    // Direction always stays with the port direction bit
    assign pin_out       = (com != COM_OFF) ? wave_ff : port_data;
    assign pin_oe        = port_dir;
    assign wave_out      = wave_ff;
    assign compare_value = buffer_ff;
    assign active_value  = active_ff;

endmodule

`default_nettype wire

// ==== verilog/timer0_wave.sv ====
// Counter, flags and waveform generation of an 8-bit timer with two
// compare channels (normal, clear-on-match and fast PWM modes).
// Assumes timer_tick is a one-cycle enable from an external prescaler
// and that all control inputs are synchronous to clk.
`default_nettype none
`timescale 1ns/10ps

module timer0_wave #(
    parameter int CNT_W = timer0_pkg::CNT_W
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             timer_tick,
    input  wire logic [2:0]       clock_source_select,
    input  wire logic [2:0]       waveform_mode_select,
    input  wire logic [1:0]       compare_output_mode_a,
    input  wire logic [1:0]       compare_output_mode_b,
    input  wire logic             force_match_strobe_a,
    input  wire logic             force_match_strobe_b,
    input  wire logic             count_wr,
    input  wire logic [CNT_W-1:0] count_wdata,
    input  wire logic             compare_a_wr,
    input  wire logic [CNT_W-1:0] compare_a_wdata,
    input  wire logic             compare_b_wr,
    input  wire logic [CNT_W-1:0] compare_b_wdata,
    input  wire logic             overflow_clr,
    input  wire logic             match_a_clr,
    input  wire logic             match_b_clr,
    input  wire logic             port_data_a,
    input  wire logic             port_dir_a,
    input  wire logic             port_data_b,
    input  wire logic             port_dir_b,
    output logic [CNT_W-1:0]      timer_count,
    output logic [CNT_W-1:0]      compare_value_a,
    output logic [CNT_W-1:0]      compare_value_b,
    output logic                  overflow_flag,
    output logic                  match_flag_a,
    output logic                  match_flag_b,
    output logic                  wave_out_a,
    output logic                  wave_out_b,
    output logic                  pin_out_a,
    output logic                  pin_oe_a,
    output logic                  pin_out_b,
    output logic                  pin_oe_b
);
    import timer0_pkg::*;

    // ************************************************************
    // Elaboration check
    // ************************************************************
    // A one-bit counter cannot tell BOTTOM from TOP
    if (CNT_W < 2) begin : g_bad_width
        $error("timer0_wave: CNT_W must be at least 2");
    end

    localparam logic [CNT_W-1:0] CNT_MAX    = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] CNT_BOTTOM = '0;
    localparam logic [CNT_W-1:0] CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};

    logic [CNT_W-1:0] count_ff;
    logic             block_ff;
    logic             overflow_ff;
    logic             match_a_ff;
    logic             match_b_ff;
    logic             run;
    logic             fast_pwm;
    logic             top_is_a;
    logic [CNT_W-1:0] top_val;
    logic             at_top;
    logic [CNT_W-1:0] active_a;
    logic [CNT_W-1:0] active_b;
    logic             match_a;
    logic             match_b;
    logic             toggle_ok_a;

    // ************************************************************
    // Mode decode
    // ************************************************************
    // Only the mode select bits feed the sequence; output modes never do
    assign run      = timer_tick && (clock_source_select != CS_STOPPED);
    assign fast_pwm = (waveform_mode_select == WGM_FAST_MAX) ||
                      (waveform_mode_select == WGM_FAST_OCRA);
    assign top_is_a = (waveform_mode_select == WGM_CLR_MATCH) ||
                      (waveform_mode_select == WGM_FAST_OCRA);
    assign top_val  = top_is_a ? active_a : CNT_MAX;
    assign at_top   = (count_ff == top_val);
    // Channel B has no toggle option in PWM modes
    assign toggle_ok_a = waveform_mode_select[WGM_BIT2];

    // ************************************************************
    // Counter
    // ************************************************************
    // A write wins; otherwise clear at TOP in the TOP-based modes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= CNT_BOTTOM;
        end else if (count_wr) begin
            count_ff <= count_wdata;
        end else if (run) begin
            if (top_is_a && at_top) begin
                count_ff <= CNT_BOTTOM;
            end else if (fast_pwm && at_top) begin
                count_ff <= CNT_BOTTOM;
            end else begin
                count_ff <= count_ff + CNT_ONE;
            end
        end
    end

    // Blocks matches until the next timer tick after a count write.
    // The blocked match is simply gone, which is why software must not
    // write the count equal to a live compare value.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            block_ff <= BLOCK_RST;
        end else if (count_wr) begin
            block_ff <= 1'b1;
        end else if (run) begin
            block_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Flags
    // ************************************************************
    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_ff <= FLAG_RST;
        end else if (run && !count_wr &&
                     (fast_pwm ? at_top : (count_ff == CNT_MAX))) begin
            overflow_ff <= 1'b1;
        end else if (overflow_clr) begin
            overflow_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            match_a_ff <= FLAG_RST;
        end else if (match_a) begin
            match_a_ff <= 1'b1;
        end else if (match_a_clr) begin
            match_a_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            match_b_ff <= FLAG_RST;
        end else if (match_b) begin
            match_b_ff <= 1'b1;
        end else if (match_b_clr) begin
            match_b_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Compare channels
    // ************************************************************
    compare_channel #(
        .CNT_W (CNT_W)
    ) u_chan_a (
        .clk           (clk),
        .reset_n       (reset_n),
        .run           (run),
        .count         (count_ff),
        .block         (block_ff),
        .wr            (compare_a_wr),
        .wdata         (compare_a_wdata),
        .fast_pwm      (fast_pwm),
        .at_top        (at_top),
        .com           (compare_output_mode_a),
        .toggle_ok     (toggle_ok_a),
        .force_strobe  (force_match_strobe_a),
        .port_data     (port_data_a),
        .port_dir      (port_dir_a),
        .compare_value (compare_value_a),
        .active_value  (active_a),
        .match         (match_a),
        .wave_out      (wave_out_a),
        .pin_out       (pin_out_a),
        .pin_oe        (pin_oe_a)
    );

    compare_channel #(
        .CNT_W (CNT_W)
    ) u_chan_b (
        .clk           (clk),
        .reset_n       (reset_n),
        .run           (run),
        .count         (count_ff),
        .block         (block_ff),
        .wr            (compare_b_wr),
        .wdata         (compare_b_wdata),
        .fast_pwm      (fast_pwm),
        .at_top        (at_top),
        .com           (compare_output_mode_b),
        .toggle_ok     (1'b0),
        .force_strobe  (force_match_strobe_b),
        .port_data     (port_data_b),
        .port_dir      (port_dir_b),
        .compare_value (compare_value_b),
        .active_value  (active_b),
        .match         (match_b),
        .wave_out      (wave_out_b),
        .pin_out       (pin_out_b),
        .pin_oe        (pin_oe_b)
    );

    assign timer_count   = count_ff;
    assign overflow_flag = overflow_ff;
    assign match_flag_a  = match_a_ff;
    assign match_flag_b  = match_b_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    // No match may be seen in the tick right after a count write
    property p_block_after_write;
        @(posedge clk) disable iff (!reset_n)
        count_wr ##1 run |-> !match_a && !match_b;
    endproperty
    a_block_after_write: assert property (p_block_after_write)
        else $error("match not blocked after count write");

    // Write value lands regardless of what the counter was doing
    property p_write_priority;
        @(posedge clk) disable iff (!reset_n)
        count_wr |=> timer_count == $past(count_wdata);
    endproperty
    a_write_priority: assert property (p_write_priority)
        else $error("count write did not take priority");

    // Stopped clock source freezes the count
    property p_stopped;
        @(posedge clk) disable iff (!reset_n)
        (clock_source_select == CS_STOPPED) && !count_wr
            |=> $stable(timer_count);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("counter moved with clock source stopped");

    // Normal mode wraps MAX to BOTTOM and raises overflow with it
    property p_normal_wrap;
        @(posedge clk) disable iff (!reset_n)
        run && !count_wr && (waveform_mode_select == WGM_NORMAL) &&
        (timer_count == CNT_MAX)
            |=> (timer_count == CNT_BOTTOM) && overflow_flag;
    endproperty
    a_normal_wrap: assert property (p_normal_wrap)
        else $error("normal mode wrap or overflow wrong");

    // Clear-on-match clears at compare A and flags the match
    property p_clear_on_match;
        @(posedge clk) disable iff (!reset_n)
        run && !count_wr && !block_ff &&
        (waveform_mode_select == WGM_CLR_MATCH) && (timer_count == active_a)
            |=> (timer_count == CNT_BOTTOM) && match_flag_a;
    endproperty
    a_clear_on_match: assert property (p_clear_on_match)
        else $error("clear-on-match did not clear at compare A");

    // Fast PWM restarts from BOTTOM after TOP and sets overflow
    property p_fast_top;
        @(posedge clk) disable iff (!reset_n)
        run && !count_wr && fast_pwm && at_top
            |=> (timer_count == CNT_BOTTOM) && overflow_flag;
    endproperty
    a_fast_top: assert property (p_fast_top)
        else $error("fast PWM did not restart at TOP");

    // Channel B match shows on its flag one clock later
    property p_match_flag;
        @(posedge clk) disable iff (!reset_n)
        match_b |=> match_flag_b;
    endproperty
    a_match_flag: assert property (p_match_flag)
        else $error("match flag B not set by match");

    // Active output mode hands the pin to the wave register
    property p_override;
        @(posedge clk) disable iff (!reset_n)
        (compare_output_mode_a != COM_OFF)
            |-> (pin_out_a == wave_out_a) && (pin_oe_a == port_dir_a);
    endproperty
    a_override: assert property (p_override)
        else $error("pin A not overridden by wave output");

    // Output mode zero leaves the wave register untouched
    property p_com_off_hold;
        @(posedge clk) disable iff (!reset_n)
        compare_output_mode_a == COM_OFF |=> $stable(wave_out_a);
    endproperty
    a_com_off_hold: assert property (p_com_off_hold)
        else $error("wave A changed with output mode zero");

    // Non-PWM toggle mode flips wave A on each match
    property p_toggle;
        @(posedge clk) disable iff (!reset_n)
        !fast_pwm && match_a && (compare_output_mode_a == COM_TOGGLE)
            |=> wave_out_a != $past(wave_out_a);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("wave A did not toggle on match");

    // Non-inverting fast PWM sets the wave at BOTTOM
    property p_fast_bottom;
        @(posedge clk) disable iff (!reset_n)
        run && fast_pwm && at_top &&
        (compare_output_mode_b == COM_CLEAR) |=> wave_out_b;
    endproperty
    a_fast_bottom: assert property (p_fast_bottom)
        else $error("wave B not set at BOTTOM");

    // Fast PWM active compare only moves at TOP to BOTTOM
    property p_buffered;
        @(posedge clk) disable iff (!reset_n)
        fast_pwm && !(run && at_top) |=> $stable(active_b);
    endproperty
    a_buffered: assert property (p_buffered)
        else $error("fast PWM compare reloaded away from TOP");

endmodule

`default_nettype wire

// ==== tb/pin_load.sv ====
// Model of the load on one output pin, with a weak pull-down.
// Assumes the pin value and drive enable come straight from the block.
`default_nettype none
`timescale 1ns/10ps
module pin_load (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      level
);
    // Undriven pin falls to the pull-down and never keeps the last value
    assign level = pin_oe ? pin_out : 1'b0;
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the timer waveform block.
// Assumes a tick every clock; expected values queue up for a watcher.
`default_nettype none
`timescale 1ns/10ps
module tb_top;
    import timer0_pkg::*;
    typedef struct {logic [3:0] sel; logic [7:0] val;} note_t;
    logic       clk, reset_n, tick, fa, fb, cw, aw, bw, oc, mac, mbc;
    logic       pda, pdb, dra, drb, lva, ovf, mfa, mfb, wva, wvb;
    logic       poa, oea, pob, oeb, lvb;
    logic [2:0] cs, wgm;
    logic [1:0] coma, comb;
    logic [7:0] cwd, awd, bwd, cnt, cva, cvb;
    int         n_fail, n_compared;
    note_t      q[$];

    timer0_wave i_timer0_wave (.clk(clk), .reset_n(reset_n),
        .timer_tick(tick), .clock_source_select(cs),
        .waveform_mode_select(wgm), .compare_output_mode_a(coma),
        .compare_output_mode_b(comb), .force_match_strobe_a(fa),
        .force_match_strobe_b(fb), .count_wr(cw), .count_wdata(cwd),
        .compare_a_wr(aw), .compare_a_wdata(awd), .compare_b_wr(bw),
        .compare_b_wdata(bwd), .overflow_clr(oc), .match_a_clr(mac),
        .match_b_clr(mbc), .port_data_a(pda), .port_dir_a(dra),
        .port_data_b(pdb), .port_dir_b(drb), .timer_count(cnt),
        .compare_value_a(cva), .compare_value_b(cvb), .overflow_flag(ovf),
        .match_flag_a(mfa), .match_flag_b(mfb), .wave_out_a(wva),
        .wave_out_b(wvb), .pin_out_a(poa), .pin_oe_a(oea),
        .pin_out_b(pob), .pin_oe_b(oeb));
    pin_load i_pin_load (.pin_out(poa), .pin_oe(oea), .level(lva));
    pin_load i_pin_load_b (.pin_out(pob), .pin_oe(oeb), .level(lvb));

    // ****************************************
    // Clock, tasks and result watcher
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic note(input logic [2:0] s, input logic [7:0] v);
        q.push_back('{{1'b0, s}, v});
    endtask

    // Second bank: flag B, compare readbacks and pin B level
    task automatic note_hi(input logic [2:0] s, input logic [7:0] v);
        q.push_back('{{1'b1, s}, v});
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic end_sim();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Sampled mid-cycle, so edge updates have landed before comparing
    always @(negedge clk) begin
        note_t n;
        while (q.size() > 0) begin
            n = q.pop_front();
            case (n.sel)
                4'h0: cmp8(cnt, n.val);
                4'h1: cmp1(wva, n.val[0]);
                4'h2: cmp1(wvb, n.val[0]);
                4'h3: cmp1(ovf, n.val[0]);
                4'h4: cmp1(mfa, n.val[0]);
                4'h8: cmp1(mfb, n.val[0]);
                4'h9: cmp8(cva, n.val);
                4'hA: cmp8(cvb, n.val);
                4'hB: cmp1(lvb, n.val[0]);
                default: cmp1(lva, n.val[0]);
            endcase
        end
    end

    // Hang guard: the whole sequence needs far fewer cycles
    initial begin
        cyc(2000);
        n_fail++;
        end_sim();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {tick, fa, fb, cw, aw, bw, oc, mac, mbc, pdb, drb} = '0;
        {cs, wgm, coma, comb, cwd, awd, bwd} = '0;
        n_fail = 0;
        n_compared = 0;
        reset_n = 1'b0;
        void'($urandom(32'h8105));
        pda = 1'($urandom);
        dra = 1'b1;
        cyc(2);
        reset_n <= 1'b1;
        tick <= 1'b1;
        cyc(3);
        note(3'h0, 8'h00);
        note(3'h1, 8'h00);
        note(3'h5, {7'h00, pda});
        note_hi(3'h3, 8'h00);
        // Normal mode: the write beats the tick, then wrap to zero
        cs <= 3'h1;
        cwd <= 8'hFE;
        cw <= 1'b1;
        cyc(1);
        cw <= 1'b0;
        note(3'h0, 8'hFE);
        cyc(2);
        note(3'h0, 8'h00);
        note(3'h3, 8'h01);
        // Count written equal to compare A; output mode is off
        cyc(1);
        awd <= 8'h40;
        cwd <= 8'h40;
        {aw, cw, mac} <= 3'b111;
        cyc(1);
        {aw, cw, mac} <= 3'b000;
        cyc(1);
        note(3'h4, 8'h00);
        note_hi(3'h1, 8'h40);
        cwd <= 8'h3F;
        cw <= 1'b1;
        cyc(1);
        cw <= 1'b0;
        cyc(1);
        note(3'h4, 8'h00);
        cyc(1);
        note(3'h4, 8'h01);
        // Clear-on-match with a toggling channel A
        wgm <= WGM_CLR_MATCH;
        coma <= COM_TOGGLE;
        awd <= 8'h03;
        cwd <= 8'h00;
        {aw, cw, mac} <= 3'b111;
        cyc(1);
        {aw, cw, mac} <= 3'b000;
        cyc(3);
        note(3'h0, 8'h03);
        note(3'h1, 8'h00);
        cyc(1);
        note(3'h0, 8'h00);
        note(3'h1, 8'h01);
        note(3'h4, 8'h01);
        note(3'h5, 8'h01);
        cyc(4);
        note(3'h1, 8'h00);
        // Forced compare on A and B away from their match values
        cyc(1);
        wgm <= WGM_NORMAL;
        comb <= COM_SET;
        {fa, fb} <= 2'b11;
        cyc(1);
        {fa, fb} <= 2'b00;
        note(3'h2, 8'h01);
        note(3'h1, 8'h01);
        // Fast PWM, TOP at 0xFF, compare B at BOTTOM gives spikes
        wgm <= WGM_FAST_MAX;
        cwd <= 8'hFE;
        {cw, oc, mbc} <= 3'b111;
        cyc(1);
        {cw, oc, mbc} <= 3'b000;
        cyc(1);
        note(3'h3, 8'h00);
        cyc(1);
        note(3'h0, 8'h00);
        note(3'h2, 8'h00);
        note(3'h3, 8'h01);
        note_hi(3'h0, 8'h00);
        cyc(1);
        note(3'h2, 8'h01);
        note_hi(3'h0, 8'h01);
        comb <= COM_CLEAR;
        cyc(3);
        note(3'h1, 8'h01);
        cyc(252);
        note(3'h2, 8'h01);
        cyc(1);
        note(3'h2, 8'h00);
        // Fast PWM with compare A as TOP lets channel A toggle
        wgm <= WGM_FAST_OCRA;
        bwd <= 8'h02;
        {bw, drb} <= 2'b11;
        cyc(1);
        bw <= 1'b0;
        cyc(2);
        note(3'h0, 8'h00);
        note(3'h1, 8'h00);
        note_hi(3'h2, 8'h02);
        note_hi(3'h3, 8'h01);
        cyc(1);
        end_sim();
    end
endmodule
`default_nettype wire
